/* File: rtl/lusf_framer.sv */
// Stream packet framer: header plus interleaved payload, one byte per handshake.
// Assumes samples arrive at the lock-in rate, synchronous to CLK_SYS_I, and that
// the UDP/IP layer downstream adds transport, checksum and drops bad packets.
`timescale 1ns/100ps
`default_nettype none
module lusf_framer (
	// Clock and reset
	input  wire logic        CLK_SYS_I,
	input  wire logic        SYS_RST_I,
	// Register port
	input  wire logic [7:0]  REG_ADDR_I,
	input  wire logic [31:0] REG_WDATA_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	output logic      [31:0] REG_RDATA_O,
	// Lock-in samples
	input  wire logic        SAMPLE_VALID_I,
	input  wire logic [31:0] SAMPLE_XF_I,
	input  wire logic [31:0] SAMPLE_YF_I,
	input  wire logic [31:0] SAMPLE_RF_I,
	input  wire logic [31:0] SAMPLE_TF_I,
	input  wire logic [15:0] SAMPLE_XI_I,
	input  wire logic [15:0] SAMPLE_YI_I,
	input  wire logic [15:0] SAMPLE_RI_I,
	input  wire logic [15:0] SAMPLE_TI_I,
	// Instrument conditions
	input  wire logic        INPUT_OVL_I,
	input  wire logic        SYNC_ON_I,
	input  wire logic        SYNC_OVL_I,
	input  wire logic        OUTPUT_OVL_I,
	input  wire logic        PLL_UNLOCK_I,
	input  wire logic        SYNC_RANGE_I,
	// Byte stream to network
	output logic      [7:0]  TX_DATA_O,
	output logic             TX_VALID_O,
	output logic             TX_FIRST_O,
	output logic             TX_LAST_O,
	input  wire logic        TX_READY_I,
	// Transport settings and interrupt
	output logic      [31:0] DEST_ADDR_O,
	output logic      [15:0] DEST_PORT_O,
	output logic             CSUM_EN_O,
	output logic             IRQ_O
);
	typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_PAY} lusf_state_e;

	lusf_state_e        state_q;
	logic        [31:0] ctrl_q;
	logic        [7:0]  pkt_cnt_q;
	logic        [31:0] hdr_q;
	logic        [1:0]  hdr_idx_q;
	logic        [10:0] remain_q;
	logic        [2:0]  cont_q;
	logic               little_q;
	logic        [1:0]  ch_idx_q;
	logic        [1:0]  b_idx_q;
	logic               samp_full_q;
	logic        [31:0] samp_f_q [4];
	logic        [15:0] samp_i_q [4];
	logic        [31:0] sub_cnt_q;
	logic        [lusf_pkg::EV_W-1:0] int_stat_q;
	logic        [lusf_pkg::EV_W-1:0] int_en_q;

	logic        [4:0]  rate_n;
	logic        [1:0]  len_code;
	logic        [2:0]  cont_code;
	logic               take;
	logic               keep;
	logic               capture;
	logic               pay_go;
	logic               samp_done;
	logic               pkt_end;
	logic        [1:0]  nch_m1;
	logic        [1:0]  nb_m1;
	logic        [1:0]  chan;
	logic        [1:0]  bpos;
	logic        [31:0] word;
	logic        [7:0]  hdr_status;
	logic        [lusf_pkg::EV_W-1:0] ev;

	assign rate_n    = ctrl_q[lusf_pkg::CTRL_RATE_LSB +: 5];
	assign len_code  = ctrl_q[lusf_pkg::CTRL_LEN_LSB +: 2];
	assign cont_code = ctrl_q[lusf_pkg::CTRL_CONT_LSB +: 3];
	// Output register free to take a new byte
	assign take      = !TX_VALID_O || TX_READY_I;

	// Keep one input sample in 2^N so the rate code matches the data
	assign keep    = (sub_cnt_q & ((32'h0000_0001 << rate_n) - 32'h0000_0001)) == 32'h0000_0000;
	assign capture = SAMPLE_VALID_I && keep && (state_q != ST_IDLE);

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			sub_cnt_q <= 32'h0000_0000;
		end else if (state_q == ST_IDLE) begin
			sub_cnt_q <= 32'h0000_0000;
		end else if (SAMPLE_VALID_I) begin
			sub_cnt_q <= sub_cnt_q + 32'h0000_0001;
		end
	end

	// Channel walk per sample instant, X Y R theta order
	always_comb begin
		nch_m1 = (cont_q[1:0] == 2'd0) ? 2'd0 : ((cont_q[1:0] == 2'd3) ? 2'd3 : 2'd1);
		chan   = (cont_q[1:0] == 2'd2) ? ch_idx_q + 2'd2 : ch_idx_q;
		nb_m1  = cont_q[2] ? 2'd1 : 2'd3;
		bpos   = little_q ? b_idx_q : nb_m1 - b_idx_q;
		word   = cont_q[2] ? {16'h0000, samp_i_q[chan]} : samp_f_q[chan];
	end

	assign pay_go    = (state_q == ST_PAY) && samp_full_q && take;
	assign samp_done = pay_go && (b_idx_q == nb_m1) && (ch_idx_q == nch_m1);
	assign pkt_end   = pay_go && (remain_q == 11'h001);

	// Sample hold; a drop while full is an overrun
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			samp_full_q <= 1'b0;
			samp_f_q    <= '{default: 32'h0000_0000};
			samp_i_q    <= '{default: 16'h0000};
		end else if (capture && (!samp_full_q || samp_done)) begin
			samp_full_q <= 1'b1;
			samp_f_q    <= '{SAMPLE_XF_I, SAMPLE_YF_I, SAMPLE_RF_I, SAMPLE_TF_I};
			samp_i_q    <= '{SAMPLE_XI_I, SAMPLE_YI_I, SAMPLE_RI_I, SAMPLE_TI_I};
		end else if (samp_done || state_q == ST_IDLE) begin
			samp_full_q <= 1'b0;
		end
	end

	// Status sampled at packet start
	always_comb begin
		hdr_status                          = 8'h00;
		hdr_status[lusf_pkg::HDR_OVL - 24]  = INPUT_OVL_I || (SYNC_ON_I && SYNC_OVL_I)
			|| (cont_code[2] && OUTPUT_OVL_I);
		hdr_status[lusf_pkg::HDR_ERR - 24]  = PLL_UNLOCK_I || SYNC_RANGE_I;
		hdr_status[lusf_pkg::HDR_LITTLE - 24] = ctrl_q[lusf_pkg::CTRL_LITTLE];
		hdr_status[lusf_pkg::HDR_CSUM - 24] = ctrl_q[lusf_pkg::CTRL_CSUM];
	end

	// Packet sequencing; content, endianness and length frozen per packet, the subsampling rate code is read live
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			state_q   <= ST_IDLE;
			hdr_q     <= 32'h0000_0000;
			hdr_idx_q <= 2'h0;
			remain_q  <= 11'h000;
			cont_q    <= 3'h0;
			little_q  <= 1'b0;
			ch_idx_q  <= 2'h0;
			b_idx_q   <= 2'h0;
			pkt_cnt_q <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (ctrl_q[lusf_pkg::CTRL_EN]) begin
						state_q   <= ST_HDR;
						hdr_q     <= {hdr_status, 3'b000, rate_n, 2'b00, len_code,
							1'b0, cont_code, pkt_cnt_q};
						hdr_idx_q <= 2'h0;
						remain_q  <= lusf_pkg::LEN_MAX >> len_code;
						cont_q    <= cont_code;
						little_q  <= ctrl_q[lusf_pkg::CTRL_LITTLE];
						ch_idx_q  <= 2'h0;
						b_idx_q   <= 2'h0;
					end
				end
				ST_HDR: begin
					if (take) begin
						hdr_idx_q <= hdr_idx_q + 2'h1;
						if (hdr_idx_q == lusf_pkg::HDR_BYTES_M1) begin
							state_q <= ST_PAY;
						end
					end
				end
				ST_PAY: begin
					if (pay_go) begin
						remain_q <= remain_q - 11'h001;
						b_idx_q  <= (b_idx_q == nb_m1) ? 2'h0 : b_idx_q + 2'h1;
						if (b_idx_q == nb_m1) begin
							ch_idx_q <= (ch_idx_q == nch_m1) ? 2'h0 : ch_idx_q + 2'h1;
						end
						if (pkt_end) begin
							state_q   <= ST_IDLE;
							pkt_cnt_q <= pkt_cnt_q + 8'h01;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Byte output register
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			TX_DATA_O  <= 8'h00;
			TX_VALID_O <= 1'b0;
			TX_FIRST_O <= 1'b0;
			TX_LAST_O  <= 1'b0;
		end else if (take) begin
			TX_VALID_O <= (state_q == ST_HDR) || pay_go;
			TX_FIRST_O <= (state_q == ST_HDR) && (hdr_idx_q == 2'h0);
			TX_LAST_O  <= pkt_end;
			if (state_q == ST_HDR) begin
				TX_DATA_O <= hdr_q[8*(3-hdr_idx_q) +: 8];
			end else begin
				TX_DATA_O <= word[8*bpos +: 8];
			end
		end
	end

	// Register writes
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ctrl_q      <= lusf_pkg::CTRL_RESET;
			DEST_ADDR_O <= 32'h0000_0000;
			DEST_PORT_O <= lusf_pkg::PORT_RESET;
			CSUM_EN_O   <= 1'b0;
			int_en_q    <= '0;
		end else if (REG_WR_I) begin
			case (REG_ADDR_I)
				lusf_pkg::ADDR_CTRL: begin
					ctrl_q    <= REG_WDATA_I;
					CSUM_EN_O <= REG_WDATA_I[lusf_pkg::CTRL_CSUM];
				end
				lusf_pkg::ADDR_DEST_IP:   DEST_ADDR_O <= REG_WDATA_I;
				lusf_pkg::ADDR_DEST_PORT: DEST_PORT_O <= REG_WDATA_I[15:0];
				lusf_pkg::ADDR_INT_EN:    int_en_q    <= REG_WDATA_I[lusf_pkg::EV_W-1:0];
				default: ;
			endcase
		end
	end

	// Sticky events; a new event beats a clear in the same cycle
	assign ev = {capture && samp_full_q && !samp_done, pkt_end};

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			int_stat_q <= '0;
			IRQ_O      <= 1'b0;
		end else begin
			int_stat_q <= (int_stat_q & ~((REG_WR_I && REG_ADDR_I == lusf_pkg::ADDR_INT_CLR)
				? REG_WDATA_I[lusf_pkg::EV_W-1:0] : '0)) | ev;
			IRQ_O      <= |(int_stat_q & int_en_q);
		end
	end

	// Register reads, unmapped reads zero
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			REG_RDATA_O <= 32'h0000_0000;
		end else if (REG_RD_I) begin
			case (REG_ADDR_I)
				lusf_pkg::ADDR_CTRL:      REG_RDATA_O <= ctrl_q;
				lusf_pkg::ADDR_DEST_IP:   REG_RDATA_O <= DEST_ADDR_O;
				lusf_pkg::ADDR_DEST_PORT: REG_RDATA_O <= {16'h0000, DEST_PORT_O};
				lusf_pkg::ADDR_STATE:     REG_RDATA_O <= {23'h0, state_q != ST_IDLE, pkt_cnt_q};
				lusf_pkg::ADDR_INT_STAT:  REG_RDATA_O <= {30'h0, int_stat_q};
				lusf_pkg::ADDR_INT_EN:    REG_RDATA_O <= {30'h0, int_en_q};
				default:                  REG_RDATA_O <= 32'h0000_0000;
			endcase
		end else begin
			REG_RDATA_O <= 32'h0000_0000;
		end
	end

	// Checking helpers: bytes handed over after the first byte of the current packet, plus its payload length
	logic [10:0] pay_seen_q;
	logic [10:0] pay_len_q;
	logic        hs;
	assign hs = TX_VALID_O && TX_READY_I;
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pay_seen_q <= 11'h000;
			pay_len_q  <= 11'h000;
		end else begin
			if (state_q == ST_HDR) begin
				pay_len_q <= remain_q;
			end
			if (hs && TX_FIRST_O) begin
				pay_seen_q <= 11'h000;
			end else if (hs) begin
				pay_seen_q <= pay_seen_q + 11'h001;
			end
		end
	end

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (SYS_RST_I);

	// First handover clears the count, so three header bytes and all but the last payload byte
	pkt_length_a: assert property (hs && TX_LAST_O |-> pay_seen_q == pay_len_q + 11'h002)
		else $error("payload count differs from length code");
	counter_step_a: assert property (pkt_end |=> pkt_cnt_q == $past(pkt_cnt_q) + 8'h01)
		else $error("packet counter did not step by one");
	len_decode_a: assert property (state_q == ST_HDR |-> remain_q == (11'h400 >> hdr_q[13:12]))
		else $error("length code and byte count disagree");
	hdr_first_a: assert property (TX_VALID_O && TX_FIRST_O |-> TX_DATA_O == hdr_q[31:24])
		else $error("first byte is not header status");
	hdr_flags_a: assert property (state_q == ST_HDR |-> hdr_q[28] == little_q && hdr_q[11:8] == cont_q)
		else $error("header flags disagree with packet setup");
	hdr_order_a: assert property (state_q == ST_HDR && hdr_idx_q == 2'h0 && take
		|=> state_q == ST_HDR && hdr_idx_q == 2'h1)
		else $error("header bytes out of order");
	irq_level_a: assert property (|(int_stat_q & int_en_q) |=> IRQ_O)
		else $error("enabled event did not raise interrupt");
	port_default_a: assert property ($rose(ctrl_q[0]) && !$past(REG_WR_I && REG_ADDR_I == 8'h08)
		&& DEST_PORT_O != $past(DEST_PORT_O) |-> 1'b0)
		else $error("destination port changed without a write");
	sample_order_a: assert property (pay_go && ch_idx_q == nch_m1 && b_idx_q == nb_m1
		|=> ch_idx_q == 2'h0 && b_idx_q == 2'h0)
		else $error("channel walk did not restart per sample");

	full_pkt_c: cover property (hs && TX_LAST_O);
	little_c: cover property (state_q == ST_HDR && little_q && cont_q[2]);
	overrun_c: cover property (ev[lusf_pkg::EV_OVERRUN]);
	wrap_c: cover property (pkt_end && pkt_cnt_q == 8'hFF);
endmodule
`default_nettype wire

/* File: shared/lusf_pkg.sv */
// Constants for the lock-in stream packet framer.
// Assumes one 125 MHz system clock and 32-bit register words.
// Behaviour
// - Each packet is a 4-byte header, always big-endian, then 128 to 1024 payload bytes.
// - The header holds status 31:24, rate code 23:16, length code 15:12, content 11:8, counter 7:0.
// - The packet counter rises by one per packet and wraps modulo 256.
// - Length code 0, 1, 2, 3 means 1024, 512, 256, 128 payload bytes.
// - Content codes 0 to 3 are float X, XY, R-theta, XYR-theta; 4 to 7 the same as 16-bit integers.
// - Rate code N means 1.25 MHz over 2 to the N, already including subsampling.
// - Status bit 24 flags input, active sync filter, or integer output overload at packet start.
// - Status bit 25 flags reference loop unlock or sync filter out of range at packet start.
// - Status bit 28 is set for little-endian payload and clear for big-endian.
// - Status bit 29 is set when the checksum integrity check is enabled.
// - Big-endian sends the most significant byte of each word first; little reverses bytes only.
// - All selected channels of one sample go out in X, Y, R, theta order before the next sample.
// - With checking on, the network hardware checks and drops a bad packet whole.
// - Packets go to the address that enabled the stream, at a port that defaults to 1865; the code sends to the address written at ADDR_DEST_IP instead.
// - Payload size follows the size setting; endianness and checksum follow the format option.
package lusf_pkg;
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_DEST_IP   = 8'h04;
	localparam logic [7:0]  ADDR_DEST_PORT = 8'h08;
	localparam logic [7:0]  ADDR_STATE     = 8'h0C;
	localparam logic [7:0]  ADDR_INT_STAT  = 8'h10;
	localparam logic [7:0]  ADDR_INT_CLR   = 8'h14;
	localparam logic [7:0]  ADDR_INT_EN    = 8'h18;
	// Control register fields
	localparam int          CTRL_EN        = 0;
	localparam int          CTRL_LEN_LSB   = 2;
	localparam int          CTRL_CONT_LSB  = 4;
	localparam int          CTRL_LITTLE    = 7;
	localparam int          CTRL_CSUM      = 8;
	localparam int          CTRL_RATE_LSB  = 16;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
	localparam logic [15:0] PORT_RESET     = 16'h0749;
	// Header field positions
	localparam int          HDR_OVL        = 24;
	localparam int          HDR_ERR        = 25;
	localparam int          HDR_LITTLE     = 28;
	localparam int          HDR_CSUM       = 29;
	localparam logic [10:0] LEN_MAX        = 11'h400;
	localparam logic [1:0]  HDR_BYTES_M1   = 2'h3;
	// Interrupt events
	localparam int          EV_DONE        = 0;
	localparam int          EV_OVERRUN     = 1;
	localparam int          EV_W           = 2;
endpackage

/* File: testbench/lusf_rx_model.sv */
// Receiving end of the framer's byte stream: logs bytes with their marks.
// Assumes the framer's clock; ready runs every other cycle when slow is set.
`timescale 1ns/100ps
`default_nettype none
module lusf_rx_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Byte stream
	input  wire logic [7:0] data_i,
	input  wire logic       valid_i,
	input  wire logic       first_i,
	input  wire logic       last_i,
	output logic            ready_o,
	// Pace
	input  wire logic       slow_i
);
	logic [9:0] rx_q[$];
	int         pkt_cnt;
	logic       ph_q;
	// Packet counted only once its last byte is in, never in part
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ready_o <= 1'h0;
			ph_q    <= 1'h0;
			pkt_cnt <= 0;
		end else begin
			ph_q    <= ~ph_q;
			ready_o <= ~slow_i | ph_q;
			if (valid_i && ready_o) begin
				rx_q.push_back({first_i, last_i, data_i});
				if (last_i)
					pkt_cnt <= pkt_cnt + 1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: testbench/lockin_udp_stream_framer_bench.sv */
// Self-checking bench for the stream framer: registers, samples, byte sink.
// Assumes lusf_rx_model as receiver and the constants of lusf_pkg.
`timescale 1ns/100ps
`default_nettype none
module lockin_udp_stream_framer_bench;
	logic        clk, rst, wr, rd, sv, slow, feed, txv, txf, txl, txr, csum, irq;
	logic        iovl, son, sovl, oovl, unl, srng;
	logic [7:0]  addr, txd;
	logic [15:0] xi, yi, ri, ti, dprt;
	logic [31:0] wd, rdat, xf, yf, rf, tf, dadr;
	int          error_cnt, checks, cyc, gap, gcnt, k, npk;

	lusf_framer i_dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
		.REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat),
		.SAMPLE_VALID_I(sv), .SAMPLE_XF_I(xf), .SAMPLE_YF_I(yf), .SAMPLE_RF_I(rf),
		.SAMPLE_TF_I(tf), .SAMPLE_XI_I(xi), .SAMPLE_YI_I(yi), .SAMPLE_RI_I(ri),
		.SAMPLE_TI_I(ti), .INPUT_OVL_I(iovl), .SYNC_ON_I(son), .SYNC_OVL_I(sovl),
		.OUTPUT_OVL_I(oovl), .PLL_UNLOCK_I(unl), .SYNC_RANGE_I(srng),
		.TX_DATA_O(txd), .TX_VALID_O(txv), .TX_FIRST_O(txf), .TX_LAST_O(txl),
		.TX_READY_I(txr), .DEST_ADDR_O(dadr), .DEST_PORT_O(dprt),
		.CSUM_EN_O(csum), .IRQ_O(irq));
	lusf_rx_model i_rx (.clk_i(clk), .rst_i(rst), .data_i(txd), .valid_i(txv),
		.first_i(txf), .last_i(txl), .ready_o(txr), .slow_i(slow));

	// Sample words carry index and channel so misplaced bytes stand out
	function automatic logic [31:0] fv(int s, int c);
		return {8'(c + 1), 8'(s), 8'(s) ^ 8'h5A, 8'(16 * c + 3)};
	endfunction
	function automatic logic [15:0] iv(int s, int c);
		return {4'(c + 1), 4'hC, 8'(s)};
	endfunction

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end
	// Sample source, one pulse every gap cycles while feed is up
	always @(posedge clk) begin
		gcnt <= (gcnt == 0) ? gap - 1 : gcnt - 1;
		sv   <= feed && gcnt == 0;
		if (!feed)
			k <= 0;
		else if (gcnt == 0) begin
			k  <= k + 1;
			xf <= fv(k, 0);
			yf <= fv(k, 1);
			rf <= fv(k, 2);
			tf <= fv(k, 3);
			xi <= iv(k, 0);
			yi <= iv(k, 1);
			ri <= iv(k, 2);
			ti <= iv(k, 3);
		end
	end

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic reg_wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd   <= d;
		wr   <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		// Read data launched at this edge; sample once it has settled
		#1;
		d = rdat;
	endtask
	task automatic wait_pk(int n);
		for (int i = 0; i < 6000 && i_rx.pkt_cnt < n; i++)
			@(posedge clk);
	endtask
	// Enable until one packet is in, then disable: the second, running packet must still finish
	task automatic run_pk(logic [31:0] ctl, int g, logic sl);
		i_rx.rx_q.delete();
		npk = i_rx.pkt_cnt;
		slow <= sl;
		gap  <= g;
		reg_wr(lusf_pkg::ADDR_CTRL, ctl | 32'h0000_0001);
		repeat (20) @(posedge clk);
		feed <= 1'h1;
		wait_pk(npk + 1);
		reg_wr(lusf_pkg::ADDR_CTRL, ctl);
		wait_pk(npk + 2);
		feed <= 1'h0;
		repeat (40) @(posedge clk);
		chk("packet count", i_rx.pkt_cnt - npk, 2);
	endtask
	// Packet p of the log: header bytes, then payload rebuilt from sample words
	task automatic chk_pkt(int p, logic [31:0] hdr, int cont, int lit, int sh, bit pay);
		int          plen, bw, nch, spb, b0, s, c, o;
		logic [31:0] w;
		plen = 1024 >> hdr[13:12];
		bw   = cont > 3 ? 2 : 4;
		nch  = cont[1:0] == 3 ? 4 : (cont[1:0] == 0 ? 1 : 2);
		spb  = bw * nch;
		b0   = p * (plen + 4);
		for (int i = 0; i < 4; i++)
			chk("header byte", i_rx.rx_q[b0 + i], 32'({i == 0, 1'h0, hdr[31 - 8 * i -: 8]}));
		for (int j = 0; pay && j < plen; j++) begin
			s = ((p * plen + j) / spb) << sh;
			o = j % spb;
			c = o / bw + ((nch == 2 && cont[1:0] == 2) ? 2 : 0);
			w = bw == 2 ? 32'(iv(s, c)) : fv(s, c);
			o = lit ? o % bw : bw - 1 - o % bw;
			chk("payload byte", i_rx.rx_q[b0 + 4 + j], 32'({j == plen - 1, w[8 * o +: 8]}));
		end
	endtask

	task automatic test_reset();
		logic [31:0] d;
		chk("dest port reset", dprt, 16'h0749);
		reg_wr(lusf_pkg::ADDR_DEST_PORT, 32'h0000_1234);
		reg_wr(lusf_pkg::ADDR_DEST_IP, 32'hC0A8_0005);
		reg_rd(lusf_pkg::ADDR_DEST_PORT, d);
		chk("dest port", {dprt, d[15:0]}, 32'h1234_1234);
		chk("dest addr", dadr, 32'hC0A8_0005);
		reg_rd(8'h40, d);
		chk("unmapped read", d, 32'h0000_0000);
		$display("test_reset done");
	endtask
	// Float XY, big-endian; sync overload ignored with filter off, float ignores output overload
	task automatic test_float();
		{iovl, son, sovl, oovl, unl, srng} <= 6'h0D;
		run_pk(32'h0000_001C, 48, 1'h1);
		chk_pkt(0, {8'h02, 8'h00, 8'h31, 8'(npk)}, 1, 0, 0, 1);
		chk_pkt(1, {8'h02, 8'h00, 8'h31, 8'(npk + 1)}, 1, 0, 0, 1);
		$display("test_float done");
	endtask
	// Integer XYR-theta, little-endian, checksum, rate code 2
	task automatic test_int();
		{iovl, son, sovl, oovl, unl, srng} <= 6'h16;
		run_pk(32'h0002_01FC, 16, 1'h0);
		chk("checksum enable", csum, 1);
		chk_pkt(0, {8'h33, 8'h02, 8'h37, 8'(npk)}, 7, 1, 2, 1);
		chk_pkt(1, {8'h33, 8'h02, 8'h37, 8'(npk + 1)}, 7, 1, 2, 0);
		$display("test_int done");
	endtask
	task automatic test_irq();
		logic [31:0] d;
		reg_wr(lusf_pkg::ADDR_INT_EN, 32'h0000_0000);
		reg_wr(lusf_pkg::ADDR_INT_CLR, 32'h0000_0003);
		slow <= 1'h1;
		gap  <= 2;
		reg_wr(lusf_pkg::ADDR_CTRL, 32'h0000_003D);
		feed <= 1'h1;
		repeat (30) @(posedge clk);
		gap <= 48;
		repeat (60) @(posedge clk);
		reg_rd(lusf_pkg::ADDR_INT_STAT, d);
		chk("overrun flag", d & 32'h0000_0002, 32'h0000_0002);
		chk("masked irq", irq, 0);
		reg_wr(lusf_pkg::ADDR_INT_EN, 32'h0000_0003);
		repeat (2) @(posedge clk);
		chk("irq raised", irq, 1);
		reg_wr(lusf_pkg::ADDR_INT_CLR, 32'h0000_0002);
		repeat (2) @(posedge clk);
		chk("irq cleared", irq, 0);
		reg_wr(lusf_pkg::ADDR_CTRL, 32'h0000_003C);
		wait_pk(i_rx.pkt_cnt + 1);
		feed <= 1'h0;
		repeat (4) @(posedge clk);
		reg_rd(lusf_pkg::ADDR_INT_STAT, d);
		chk("done flag", {d[0], irq}, 2'h3);
		$display("test_irq done");
	endtask

	initial begin
		{rst, wr, rd, slow, feed} = 5'h10;
		{iovl, son, sovl, oovl, unl, srng} = 6'h00;
		{xf, yf, rf, tf, xi, yi, ri, ti} = '0;
		addr = 8'h00;
		wd   = 32'h0000_0000;
		gap  = 48;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		test_reset();
		test_float();
		test_int();
		test_irq();
		give_verdict();
	end
endmodule
`default_nettype wire
